// [src/tws_pkg.sv]
// constants and types for the thermometer single-wire slave
package tws_pkg;
   // ---------------------------------------------
   // timebase
   // ---------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int US_CYC = CLK_HZ / 1_000_000;
   // ---------------------------------------------
   // link times in microseconds
   // ---------------------------------------------
   localparam logic [8:0] RESET_LOW_US = 9'd480;
   localparam logic [8:0] PRES_WAIT_US = 9'd30;
   localparam logic [8:0] PRES_LOW_US = 9'd120;
   localparam logic [8:0] WR_SAMPLE_US = 9'd30;
   localparam logic [8:0] RD_HOLD_US = 9'd15;
   // ---------------------------------------------
   // function opcodes
   // ---------------------------------------------
   localparam logic [7:0] OP_WR_UPPER = 8'h01;
   localparam logic [7:0] OP_WR_LOWER = 8'h02;
   localparam logic [7:0] OP_RD_UPPER = 8'hA1;
   localparam logic [7:0] OP_RD_LOWER = 8'hA2;
   localparam logic [7:0] OP_WR_CFG = 8'h0C;
   localparam logic [7:0] OP_RD_CFG = 8'hAC;
   localparam logic [7:0] OP_RD_TEMP = 8'hAA;
   localparam logic [7:0] OP_CONV_GO = 8'hEE;
   localparam logic [7:0] OP_CONV_HALT = 8'h22;
   localparam logic [7:0] OP_RD_COUNT = 8'hA0;
   localparam logic [7:0] OP_LD_COUNT = 8'h41;
   // ---------------------------------------------
   // status/configuration layout
   // ---------------------------------------------
   localparam int CFG_SINGLE = 0;
   localparam int CFG_WR_W = 5;
   localparam logic [4:0] CFG_RST = 5'h00;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [8:0] COUNT_RST = 9'h000;
   localparam logic [3:0] BITS_BYTE = 4'h8;
   localparam logic [3:0] BITS_COUNT = 4'h9;
   localparam int FIFO_W = 8;
   localparam int FIFO_D = 32;
   // one read-out request to the link side
   typedef struct packed {
      logic [8:0] data;
      logic [3:0] nbits;
   } tws_tx_t;
endpackage : tws_pkg

// [src/tws_slave.sv]
// single-wire thermometer slave: link, byte fifo and command executor
//
// Functional notes
// RQ1: reset and presence precede command and data
// RQ2: 01h/02h load upper/lower trip register
// RQ3: A1h/A2h return upper/lower trip register
// RQ4: 0Ch writes status/configuration register
// RQ5: ACh returns status/configuration register
// RQ6: AAh returns last converted temperature
// RQ7: EEh starts conversion, single or repeating
// RQ8: 22h halts repeating conversion only
// RQ9: A0h returns nine-bit counter register
// RQ10: 41h copies slope accumulator into counter
// RQ11: master opens every slot; slave only presence
// RQ12: master reset low at least 480 us
// RQ13: presence 15-60 us after rise, 60-240 long
// RQ14: line low past 480 us resets protocol
// RQ15: one data bit per time slot
// RQ16: least significant bit first both ways
// RQ17: write slot 60 us, 1 us recovery
// RQ18: master releases within 15 us for one
// RQ19: master holds low whole slot for zero
// RQ20: slave samples write slot 15-60 us in
// RQ21: slave sends only inside read slots
// RQ22: read slot opens low 1 us, lasts 60
// RQ23: slave pulls low for zero, then releases
// RQ24: read bit held valid 15 us from edge
// RQ25: master samples late in 15 us window
// RQ26: unknown opcode ignored until next reset
// RQ27: after last bit idle until new reset
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------
// byte fifo between link receiver and executor
// ---------------------------------------------
module tws_fifo #(
   parameter int W = 8,
   parameter int D = 32
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0] wr_reg, rd_reg;
   logic push, pop;
   // honest full and empty from pointer compare
   assign out_valid = wr_reg != rd_reg;
   assign in_ready = (wr_reg[AW] == rd_reg[AW]) || (wr_reg[AW-1:0] != rd_reg[AW-1:0]);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_reg[AW-1:0]];

   // storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_reg[AW-1:0]] <= in_data;
      end
   end

   // pointers
   always_ff @(posedge clk) begin
      if (!nrst || flush) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= rd_reg + 1'b1;
         end
      end
   end
endmodule : tws_fifo

// ---------------------------------------------
// top: slave behind the open-drain data pin
// ---------------------------------------------
module tws_slave (
   input wire logic CORE_CLK,
   input wire logic NRST,
   input wire logic DQ_IN,
   output logic DQ_OUT,
   output logic DQ_OE,
   input wire logic [7:0] TEMP_IN,
   input wire logic [8:0] SLOPE_IN,
   input wire logic CONV_DONE,
   output logic CONV_RUN,
   output logic [7:0] UPPER_TRIP,
   output logic [7:0] LOWER_TRIP,
   output logic [7:0] STATUS_CFG
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_RSTL = 3'b001, ST_PWAIT = 3'b010,
      ST_PRES = 3'b011, ST_RX = 3'b100, ST_TX = 3'b101
   } tws_link_t;
   typedef enum logic [1:0] {
      EX_OP = 2'b00, EX_DATA = 2'b01, EX_HALT = 2'b10
   } tws_exec_t;
   tws_link_t st_reg, st_next;
   tws_exec_t ex_reg, ex_next;
   logic dq_prev_reg, in_slot_reg, drive_reg, push_reg, done_reg, run_reg;
   logic [6:0] div_reg;
   logic [8:0] tmr_reg, lo_reg, tx_sh_reg, count_reg;
   logic [2:0] rx_cnt_reg;
   logic [3:0] tx_left_reg;
   logic [7:0] rx_sh_reg, op_reg, upper_trip_reg, lower_trip_reg, temp_reg;
   logic [4:0] cfg_reg;
   // decoded strobes and fifo handshake
   logic fall, rise, tick, tmr_clr, long_low, rx_take, rx_bit, tx_open, tx_close, pres_end;
   logic fifo_ready, fifo_valid, fifo_pop, take_op, take_data, op_write, op_read, go_idle;
   logic tx_valid, conv_go, conv_halt, single;
   logic [7:0] fifo_data, status_val;
   tws_pkg::tws_tx_t tx_req;
   // ---------------------------------------------
   // line edges, microsecond tick, timers
   // ---------------------------------------------
   assign fall = dq_prev_reg & ~DQ_IN;
   assign rise = ~dq_prev_reg & DQ_IN;
   assign tick = div_reg == 7'(tws_pkg::US_CYC - 1);
   assign tmr_clr = fall | (st_next != st_reg);
   // only while still low, so the ending rise can start presence
   assign long_low = !DQ_IN && lo_reg >= tws_pkg::RESET_LOW_US; // RQ14

   // divider restarts on every slot edge for exact slot timing
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         dq_prev_reg <= 1'b1;
         div_reg <= '0;
         tmr_reg <= '0;
         lo_reg <= '0;
      end else begin
         dq_prev_reg <= DQ_IN;
         div_reg <= (tmr_clr || tick) ? '0 : div_reg + 1'b1;
         if (tmr_clr) begin
            tmr_reg <= '0;
         end else if (tick && tmr_reg != '1) begin
            tmr_reg <= tmr_reg + 1'b1;
         end
         if (DQ_IN) begin
            lo_reg <= '0;
         end else if (tick && !long_low) begin
            lo_reg <= lo_reg + 1'b1;
         end
      end
   end

   // ---------------------------------------------
   // link state machine
   // ---------------------------------------------
   assign pres_end = st_reg == ST_PRES && tmr_reg == tws_pkg::PRES_LOW_US;
   // write slot opens on a fall, stalls while a byte waits for room
   assign rx_take = in_slot_reg && st_reg == ST_RX && tmr_reg == tws_pkg::WR_SAMPLE_US; // RQ20
   assign rx_bit = DQ_IN; // RQ20
   assign tx_open = st_reg == ST_TX && fall && !in_slot_reg && tx_left_reg != '0; // RQ21
   assign tx_close = st_reg == ST_TX && in_slot_reg && tmr_reg == tws_pkg::RD_HOLD_US; // RQ24

   always_comb begin
      st_next = st_reg;
      unique case (st_reg)
         ST_IDLE: st_next = ST_IDLE; // RQ26
         ST_RSTL: if (rise) st_next = ST_PWAIT; // RQ13
         ST_PWAIT: if (tmr_reg == tws_pkg::PRES_WAIT_US) st_next = ST_PRES; // RQ13
         ST_PRES: if (pres_end) st_next = ST_RX; // RQ1
         ST_RX: begin
            if (tx_valid) st_next = ST_TX; // RQ21
            else if (go_idle) st_next = ST_IDLE; // RQ27
         end
         ST_TX: if (tx_left_reg == '0 && !in_slot_reg) st_next = ST_IDLE; // RQ27
         default: st_next = ST_IDLE;
      endcase
      if (long_low) begin
         st_next = ST_RSTL; // RQ14
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         st_reg <= ST_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // slot tracking and pin drive
   always_ff @(posedge CORE_CLK) begin
      if (!NRST || long_low) begin
         in_slot_reg <= 1'b0;
         drive_reg <= 1'b0;
      end else if (st_reg == ST_PWAIT) begin
         drive_reg <= tmr_reg == tws_pkg::PRES_WAIT_US; // RQ11
      end else if (pres_end) begin
         drive_reg <= 1'b0; // RQ13
         in_slot_reg <= 1'b0;
      end else if (st_reg == ST_RX && fall && !in_slot_reg && !push_reg) begin
         in_slot_reg <= 1'b1; // RQ15
      end else if (rx_take) begin
         in_slot_reg <= 1'b0;
      end else if (tx_open) begin
         in_slot_reg <= 1'b1;
         drive_reg <= ~tx_sh_reg[0]; // RQ23
      end else if (tx_close) begin
         in_slot_reg <= 1'b0;
         drive_reg <= 1'b0; // RQ23
      end
   end

   // receive shifter, least significant bit first
   always_ff @(posedge CORE_CLK) begin
      if (!NRST || pres_end) begin
         rx_sh_reg <= '0;
         rx_cnt_reg <= '0;
         push_reg <= 1'b0;
      end else begin
         if (rx_take) begin
            rx_sh_reg <= {rx_bit, rx_sh_reg[7:1]}; // RQ16
            rx_cnt_reg <= rx_cnt_reg + 1'b1;
            push_reg <= rx_cnt_reg == 3'd7;
         end else if (fifo_ready) begin
            push_reg <= 1'b0;
         end
      end
   end

   // transmit shifter, least significant bit first
   always_ff @(posedge CORE_CLK) begin
      if (!NRST || long_low) begin
         tx_sh_reg <= '0;
         tx_left_reg <= '0;
      end else if (st_reg == ST_RX && tx_valid) begin
         tx_sh_reg <= tx_req.data;
         tx_left_reg <= tx_req.nbits;
      end else if (tx_close) begin
         tx_sh_reg <= {1'b0, tx_sh_reg[8:1]}; // RQ16
         tx_left_reg <= tx_left_reg - 1'b1; // RQ15
      end
   end

   // ---------------------------------------------
   // byte fifo
   // ---------------------------------------------
   tws_fifo #(.W(tws_pkg::FIFO_W), .D(tws_pkg::FIFO_D)) u_fifo (
      .clk(CORE_CLK),
      .nrst(NRST),
      .flush(pres_end),
      .in_valid(push_reg),
      .in_ready(fifo_ready),
      .in_data(rx_sh_reg),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   // ---------------------------------------------
   // command decode
   // ---------------------------------------------
   assign fifo_pop = fifo_valid && (ex_reg == EX_OP || ex_reg == EX_DATA);
   assign take_op = fifo_pop && ex_reg == EX_OP; // RQ1
   assign take_data = fifo_pop && ex_reg == EX_DATA;
   assign op_write = fifo_data == tws_pkg::OP_WR_UPPER || fifo_data == tws_pkg::OP_WR_LOWER
      || fifo_data == tws_pkg::OP_WR_CFG;
   assign op_read = tx_req.nbits != '0;
   assign single = cfg_reg[tws_pkg::CFG_SINGLE];
   assign status_val = {done_reg, 1'b1, 1'b0, cfg_reg};
   assign conv_go = take_op && fifo_data == tws_pkg::OP_CONV_GO; // RQ7
   assign conv_halt = take_op && fifo_data == tws_pkg::OP_CONV_HALT && !single; // RQ8
   assign tx_valid = take_op && op_read; // RQ21
   // anything not a read or a write ends the exchange
   assign go_idle = (take_op && !op_write && !op_read) || take_data; // RQ26

   // read-out selection
   always_comb begin
      tx_req = '0;
      unique case (fifo_data)
         tws_pkg::OP_RD_UPPER: tx_req = '{{1'b0, upper_trip_reg}, tws_pkg::BITS_BYTE}; // RQ3
         tws_pkg::OP_RD_LOWER: tx_req = '{{1'b0, lower_trip_reg}, tws_pkg::BITS_BYTE}; // RQ3
         tws_pkg::OP_RD_CFG: tx_req = '{{1'b0, status_val}, tws_pkg::BITS_BYTE}; // RQ5
         tws_pkg::OP_RD_TEMP: tx_req = '{{1'b0, temp_reg}, tws_pkg::BITS_BYTE}; // RQ6
         tws_pkg::OP_RD_COUNT: tx_req = '{count_reg, tws_pkg::BITS_COUNT}; // RQ9
         default: tx_req = '{9'h000, 4'h0};
      endcase
   end

   // executor state
   always_comb begin
      ex_next = ex_reg;
      unique case (ex_reg)
         EX_OP: if (take_op) ex_next = op_write ? EX_DATA : EX_HALT;
         EX_DATA: if (take_data) ex_next = EX_HALT; // RQ27
         EX_HALT: ex_next = EX_HALT;
         default: ex_next = EX_HALT;
      endcase
      if (pres_end) begin
         ex_next = EX_OP; // RQ1
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         ex_reg <= EX_HALT;
         op_reg <= '0;
      end else begin
         ex_reg <= ex_next;
         if (take_op) begin
            op_reg <= fifo_data;
         end
      end
   end

   // ---------------------------------------------
   // device registers
   // ---------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         upper_trip_reg <= tws_pkg::BYTE_RST;
         lower_trip_reg <= tws_pkg::BYTE_RST;
         cfg_reg <= tws_pkg::CFG_RST;
         count_reg <= tws_pkg::COUNT_RST;
      end else begin
         if (take_data && op_reg == tws_pkg::OP_WR_UPPER) begin
            upper_trip_reg <= fifo_data; // RQ2
         end
         if (take_data && op_reg == tws_pkg::OP_WR_LOWER) begin
            lower_trip_reg <= fifo_data; // RQ2
         end
         if (take_data && op_reg == tws_pkg::OP_WR_CFG) begin
            cfg_reg <= fifo_data[tws_pkg::CFG_WR_W-1:0]; // RQ4
         end
         if (take_op && fifo_data == tws_pkg::OP_LD_COUNT) begin
            count_reg <= SLOPE_IN; // RQ10
         end
      end
   end

   // conversion control; a restart wins over a finishing conversion for the run flag, while the done flag still sets
   always_ff @(posedge CORE_CLK) begin
      if (!NRST) begin
         run_reg <= 1'b0;
         done_reg <= 1'b0;
         temp_reg <= tws_pkg::BYTE_RST;
      end else begin
         if (CONV_DONE) begin
            temp_reg <= TEMP_IN; // RQ6
         end
         done_reg <= CONV_DONE | (done_reg & ~conv_go);
         if (conv_go) begin
            run_reg <= 1'b1; // RQ7
         end else if (conv_halt || (CONV_DONE && single)) begin
            run_reg <= 1'b0; // RQ7
         end
      end
   end

   // ---------------------------------------------
   // outputs
   // ---------------------------------------------
   assign DQ_OUT = 1'b0;
   assign DQ_OE = drive_reg;
   assign CONV_RUN = run_reg;
   assign UPPER_TRIP = upper_trip_reg;
   assign LOWER_TRIP = lower_trip_reg;
   assign STATUS_CFG = status_val;
endmodule : tws_slave
`default_nettype wire

// [testbench/tws_slave_checker.sv]
// checker: timing and register relations at the slave's ports
`timescale 1ns/10ps
`default_nettype none
module tws_slave_checker (
   input wire logic CORE_CLK,
   input wire logic NRST,
   input wire logic DQ_IN,
   input wire logic DQ_OUT,
   input wire logic DQ_OE,
   input wire logic [7:0] TEMP_IN,
   input wire logic [8:0] SLOPE_IN,
   input wire logic CONV_DONE,
   input wire logic CONV_RUN,
   input wire logic [7:0] UPPER_TRIP,
   input wire logic [7:0] LOWER_TRIP,
   input wire logic [7:0] STATUS_CFG
);
   logic [15:0] hi_cnt_reg;
   logic [15:0] oe_cnt_reg;
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!NRST);
   // length of the wire's high stretch and of the slave's drive
   always_ff @(posedge CORE_CLK) begin
      if (!NRST || !DQ_IN) begin
         hi_cnt_reg <= 16'h0000;
      end else if (hi_cnt_reg != 16'hffff) begin
         hi_cnt_reg <= hi_cnt_reg + 16'h0001;
      end
   end
   always_ff @(posedge CORE_CLK) begin
      if (!NRST || !DQ_OE) begin
         oe_cnt_reg <= 16'h0000;
      end else begin
         oe_cnt_reg <= oe_cnt_reg + 16'h0001;
      end
   end
   chk_reset_vals: assert property (
      disable iff (1'b0) !NRST |=> !DQ_OE && !CONV_RUN && UPPER_TRIP == 8'h00
      && LOWER_TRIP == 8'h00 && STATUS_CFG == 8'h40)
      else $error("values wrong after reset");
   chk_pin_open: assert property (DQ_OUT == 1'b0)
      else $error("data pin driven high");
   chk_drive_cause: assert property ($rose(DQ_OE) |-> hi_cnt_reg == 16'h0000
      || (hi_cnt_reg >= 16'h05dc && hi_cnt_reg <= 16'h1770))
      else $error("drive without master slot or presence wait");
   chk_drive_len: assert property ($fell(DQ_OE) |->
      (oe_cnt_reg >= 16'h05d2 && oe_cnt_reg <= 16'h05e6)
      || (oe_cnt_reg >= 16'h1770 && oe_cnt_reg <= 16'h5dc0))
      else $error("drive length wrong");
   chk_done_set: assert property (CONV_DONE |=> STATUS_CFG[7])
      else $error("done flag not set");
   chk_single_stop: assert property (CONV_DONE && STATUS_CFG[0] |=> !CONV_RUN)
      else $error("single conversion kept running");
   chk_halt_mode: assert property (
      $fell(CONV_RUN) |-> $past(CONV_DONE) || !$past(STATUS_CFG[0]))
      else $error("halt acted in single mode");
   chk_start_clears: assert property (
      $rose(CONV_RUN) && !$past(CONV_DONE) |-> !STATUS_CFG[7])
      else $error("start left done flag set");
   chk_cfg_fixed: assert property (STATUS_CFG[6:5] == 2'b10)
      else $error("fixed status bits wrong");
   // main scenarios reached
   cov_presence: cover property ($rose(DQ_OE) && hi_cnt_reg != 16'h0000);
   cov_read_zero: cover property ($rose(DQ_OE) && hi_cnt_reg == 16'h0000);
   cov_halt: cover property ($fell(CONV_RUN) && !STATUS_CFG[0]);
endmodule : tws_slave_checker
bind tws_slave tws_slave_checker i_tws_slave_checker (
   .CORE_CLK(CORE_CLK), .NRST(NRST), .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE),
   .TEMP_IN(TEMP_IN), .SLOPE_IN(SLOPE_IN), .CONV_DONE(CONV_DONE), .CONV_RUN(CONV_RUN),
   .UPPER_TRIP(UPPER_TRIP), .LOWER_TRIP(LOWER_TRIP), .STATUS_CFG(STATUS_CFG));
`default_nettype wire

// [testbench/tws_master.sv]
// bus master model that opens and times every slot on the shared wire
`timescale 1ns/10ps
`default_nettype none
module tws_master (
   input wire logic clk,
   input wire logic line,
   output logic low
);
   initial low = 1'b0;
   // wait whole microseconds, changes land just after an edge
   task automatic wait_us(input int n);
      repeat (n * 100) @(posedge clk);
      #1;
   endtask : wait_us
   // reset pulse, then look for the presence answer
   task automatic bus_reset(output logic pres);
      low = 1'b1;
      wait_us(481);
      low = 1'b0;
      wait_us(10);
      pres = line;
      wait_us(50);
      pres = pres & !line;
      wait_us(80);
      pres = pres & !line;
      wait_us(30);
      pres = pres & line;
   endtask : bus_reset
   // write slots, low bit first
   task automatic wr_bits(input logic [8:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         low = 1'b1;
         wait_us(5);
         low = !v[i];
         wait_us(57);
         low = 1'b0;
         wait_us(2);
      end
   endtask : wr_bits
   // read slots, low bit first, sampled late in the valid window
   task automatic rd_bits(output logic [8:0] v, input int n);
      v = 9'h000;
      for (int i = 0; i < n; i++) begin
         low = 1'b1;
         wait_us(2);
         low = 1'b0;
         wait_us(10);
         v[i] = line;
         wait_us(52);
      end
   endtask : rd_bits
endmodule : tws_master
`default_nettype wire

// [testbench/tb.sv]
// testbench: directed command scenarios for the single-wire slave
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam int LIMIT = 5_000_000;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] temp = 8'h00;
   logic [8:0] slope = 9'h000;
   logic done = 1'b0;
   logic [8:0] rd;
   logic pres;
   wire logic dq_out, dq_oe, m_low, line, run;
   wire logic [7:0] upper, lower, cfg;
   int bad_count = 0;
   int checks_done = 0;
   int cyc = 0;
   always #5 clk = ~clk;
   // open-drain wire with pull-up
   assign line = !(m_low || (dq_oe && !dq_out));
   tws_slave i_tws_slave (
      .CORE_CLK(clk), .NRST(nrst), .DQ_IN(line), .DQ_OUT(dq_out), .DQ_OE(dq_oe),
      .TEMP_IN(temp), .SLOPE_IN(slope), .CONV_DONE(done), .CONV_RUN(run),
      .UPPER_TRIP(upper), .LOWER_TRIP(lower), .STATUS_CFG(cfg));
   tws_master i_tws_master (.clk(clk), .line(line), .low(m_low));
   task automatic wrap_up();
      if (bad_count == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         bad_count++;
         wrap_up();
      end
   end
   task automatic check(input logic [8:0] got, input logic [8:0] exp, input string msg);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %0t %s", $time, msg);
      end
   endtask : check
   // reset, presence and opcode at the head of a command
   task automatic start(input logic [7:0] op);
      i_tws_master.bus_reset(pres);
      check({8'h00, pres}, 9'h001, "no presence");
      i_tws_master.wr_bits({1'b0, op}, 8);
   endtask : start
   task automatic get(input int n, input logic [8:0] exp, input string msg);
      i_tws_master.rd_bits(rd, n);
      check(rd, exp, msg);
   endtask : get
   // one-cycle completion from the conversion engine
   task automatic pulse(input logic [7:0] t);
      temp = t;
      done = 1'b1;
      @(posedge clk);
      #1 done = 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask : pulse
   task automatic sc_trips();
      start(tws_pkg::OP_WR_UPPER);
      i_tws_master.wr_bits(9'h028, 8);
      start(tws_pkg::OP_WR_LOWER);
      i_tws_master.wr_bits(9'h00a, 8);
      i_tws_master.wr_bits(9'h002, 8);
      i_tws_master.wr_bits(9'h055, 8);
      check({1'b0, upper}, 9'h028, "upper trip");
      check({1'b0, lower}, 9'h00a, "lower trip");
      start(tws_pkg::OP_RD_UPPER);
      get(8, 9'h028, "read upper");
      start(tws_pkg::OP_RD_LOWER);
      get(8, 9'h00a, "read lower");
   endtask : sc_trips
   task automatic sc_cfg();
      start(tws_pkg::OP_WR_CFG);
      i_tws_master.wr_bits(9'h0e1, 8);
      check({1'b0, cfg}, 9'h041, "status write");
      start(tws_pkg::OP_RD_CFG);
      get(8, 9'h041, "read status");
   endtask : sc_cfg
   task automatic sc_single();
      start(tws_pkg::OP_CONV_GO);
      check({run, cfg}, 9'h141, "single start");
      start(tws_pkg::OP_CONV_HALT);
      check({run, cfg}, 9'h141, "halt in single mode");
      pulse(8'h19);
      check({run, cfg}, 9'h0c1, "single finish");
      start(tws_pkg::OP_RD_TEMP);
      get(8, 9'h019, "read temp");
   endtask : sc_single
   task automatic sc_cont();
      start(tws_pkg::OP_WR_CFG);
      i_tws_master.wr_bits(9'h000, 8);
      start(tws_pkg::OP_CONV_GO);
      check({run, cfg}, 9'h140, "repeat start");
      pulse(8'he7);
      check({run, cfg}, 9'h1c0, "repeat goes on");
      start(tws_pkg::OP_CONV_HALT);
      check({8'h00, run}, 9'h000, "halt repeat");
      start(tws_pkg::OP_RD_TEMP);
      get(8, 9'h0e7, "read temp again");
   endtask : sc_cont
   task automatic sc_count();
      slope = 9'h1a5;
      start(tws_pkg::OP_LD_COUNT);
      slope = 9'h0f0;
      start(tws_pkg::OP_RD_COUNT);
      get(9, 9'h1a5, "read counter");
   endtask : sc_count
   task automatic sc_unknown();
      start(8'h5a);
      get(8, 9'h0ff, "unknown opcode drove wire");
   endtask : sc_unknown
   task automatic sc_abort();
      start(tws_pkg::OP_WR_LOWER);
      i_tws_master.wr_bits(9'h000, 4);
      start(tws_pkg::OP_RD_LOWER);
      get(8, 9'h00a, "abort by long low");
   endtask : sc_abort
   // reset, then the scenarios in turn
   initial begin
      repeat (5) @(posedge clk);
      #1 nrst = 1'b1;
      sc_trips();
      sc_cfg();
      sc_single();
      sc_cont();
      sc_count();
      sc_unknown();
      sc_abort();
      wrap_up();
   end
endmodule : tb
`default_nettype wire
